// ===== dbg_trig_pkg.sv
// Constants for the debug trigger and run-status block.
// Assumes a classic Wishbone slave with 32-bit data, registers in low byte.
// Function
// - Setup writable only while disarmed; bits 5:4 zero
// - Execution qualify routes matches through opcode tracking
// - Start select: circular fill or trigger-started storage
// - Event-only modes always behave as begin trace
// - Modes 0-2: A, A or B, A then B
// - Modes 3-4: store every B, after A
// - Modes 5-6: address A with data B / not B
// - Modes 7-8: inside or outside address range
// - Mode codes 9 to 15 never trigger
// - A hit flag clears at start, sets on match
// - B hit flag clears at start, sets on match
// - Run active flag mirrors capture enable bit
// - Run ends on full (begin) or trigger (end)
// - Writing zero to enable bits ends run
// - Valid count clears at start, latched at end
// - Valid count unchanged by FIFO reads
// - Run status is read only
// - Low byte read advances FIFO while disarmed; high does not
// - Break request: end trace on trigger, begin on full
package dbg_trig_pkg;
    // Byte addresses of the register words
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_TRIGGER_SETUP = 8'h04;
    localparam logic [7:0] OFS_RUN_STATUS = 8'h08;
    localparam logic [7:0] OFS_FIFO_HIGH_BYTE = 8'h0C;
    localparam logic [7:0] OFS_FIFO_LOW_BYTE = 8'h10;
    // Control register fields
    localparam int CTL_DEBUG_UNIT_ENABLE = 7;
    localparam int CTL_CAPTURE_ENABLE = 6;
    localparam int CTL_BREAK_TAG = 5;
    localparam int CTL_BREAK_REQUEST_ENABLE = 4;
    // Trigger setup fields
    localparam int TS_EXECUTION_QUALIFY_SELECT = 7;
    localparam int TS_START_ON_TRIGGER = 6;
    localparam logic [7:0] TS_WRITE_MASK = 8'hCF;
    // Run status fields
    localparam int RS_A_HIT = 7;
    localparam int RS_B_HIT = 6;
    localparam int RS_RUN_ACTIVE = 5;
    // Values after reset
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] TRIGGER_SETUP_RESET = 8'h00;
    localparam logic [3:0] VALID_COUNT_RESET = 4'h0;
    // Trigger mode field encodings
    typedef enum logic [3:0] {
        MODE_A_ONLY = 4'h0,
        MODE_A_OR_B = 4'h1,
        MODE_A_THEN_B = 4'h2,
        MODE_EVENT_B = 4'h3,
        MODE_A_THEN_EVENT_B = 4'h4,
        MODE_A_AND_DATA_B = 4'h5,
        MODE_A_AND_NOT_DATA_B = 4'h6,
        MODE_INSIDE_RANGE = 4'h7,
        MODE_OUTSIDE_RANGE = 4'h8
    } trig_mode_t;
    // Sequence tracker for the two-step modes
    typedef enum logic {
        SEQ_WAIT_A = 1'b0,
        SEQ_A_SEEN = 1'b1
    } seq_state_t;
endpackage

// ===== debug_trigger_status_control.sv
// Trigger selection, run control and status of the debug trace unit.
// Assumes comparator, opcode tracking and FIFO logic on the same clock.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module debug_trigger_status_control
    import dbg_trig_pkg::*;
#(
    parameter int COUNT_W = 4 // Width of the valid word count
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Bus watch inputs from the comparators
    input wire logic bus_cycle,
    input wire logic match_a,
    input wire logic match_b,
    input wire logic data_match_b,
    input wire logic addr_below_a,
    input wire logic addr_above_b,
    // Opcode tracking: the opcode at the matched address executed
    input wire logic exec_a,
    input wire logic exec_b,
    // FIFO side
    input wire logic fifo_full,
    input wire logic [COUNT_W-1:0] fifo_count,
    input wire logic [7:0] fifo_low_byte,
    input wire logic [7:0] fifo_high_byte,
    output logic fifo_advance,
    output logic store_enable,
    output logic store_event,
    output logic fifo_clear,
    // CPU break request
    output logic break_request,
    output logic break_tag
);

    // The count must hold 0 to 8 and fit the status field
    if (COUNT_W != 4) begin : g_count_w_check
        $error("COUNT_W must be 4");
    end

    logic [7:0] control_q; // Enable, capture enable, tag, break enable
    logic [7:0] trigger_setup_q; // Qualify, start select, mode
    logic a_hit_q; // Comparator A hit since arming
    logic b_hit_q; // Comparator B hit since arming
    logic [3:0] valid_count_q; // Words valid at end of run
    logic storing_q; // Begin trace has started storing
    seq_state_t seq_q; // A-then-B progress
    logic ack_q;
    logic [31:0] rdata_q;
    logic advance_q;
    logic store_en_q;
    logic store_evt_q;
    logic clear_q;
    logic brk_q;

    // Bus decode; a request completes on the edge where ack is high
    logic req;
    logic wr_fire;
    logic rd_fire;
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_fire = req & wb_we_i & ack_q & wb_sel_i[0];
    assign rd_fire = req & ~wb_we_i & ack_q;

    logic armed;
    logic unit_en;
    assign armed = control_q[CTL_CAPTURE_ENABLE];
    assign unit_en = control_q[CTL_DEBUG_UNIT_ENABLE];

    // Run start: a write that sets capture enable with the unit enabled
    logic ctl_wr;
    logic run_start;
    logic manual_stop;
    assign ctl_wr = wr_fire & (wb_adr_i == OFS_CONTROL);
    assign run_start = ctl_wr & wb_dat_i[CTL_CAPTURE_ENABLE]
                     & wb_dat_i[CTL_DEBUG_UNIT_ENABLE] & ~armed;
    assign manual_stop = ctl_wr & armed & (~wb_dat_i[CTL_CAPTURE_ENABLE]
                       | ~wb_dat_i[CTL_DEBUG_UNIT_ENABLE]);

    // Qualified matches: tag type waits for the opcode to execute
    logic qual;
    logic ma;
    logic mb;
    assign qual = trigger_setup_q[TS_EXECUTION_QUALIFY_SELECT];
    assign ma = qual ? exec_a : match_a;
    assign mb = qual ? exec_b : match_b;

    // Each bus cycle is sampled once, and only during a run
    logic sample;
    assign sample = bus_cycle & armed & unit_en;

    trig_mode_t mode;
    assign mode = trig_mode_t'(trigger_setup_q[3:0]);

    // Trigger and event decode per mode
    logic trig;
    logic evt;
    logic event_only;
    always_comb begin
        trig = 1'b0;
        evt = 1'b0;
        event_only = 1'b0;
        case (mode)
            MODE_A_ONLY: begin
                trig = ma;
            end
            MODE_A_OR_B: begin
                trig = ma | mb;
            end
            MODE_A_THEN_B: begin
                trig = (seq_q == SEQ_A_SEEN) & mb;
            end
            MODE_EVENT_B: begin
                event_only = 1'b1;
                evt = mb;
            end
            MODE_A_THEN_EVENT_B: begin
                event_only = 1'b1;
                evt = (seq_q == SEQ_A_SEEN) & mb;
            end
            MODE_A_AND_DATA_B: begin
                trig = ma & data_match_b;
            end
            MODE_A_AND_NOT_DATA_B: begin
                trig = ma & ~data_match_b;
            end
            MODE_INSIDE_RANGE: begin
                trig = ~addr_below_a & ~addr_above_b;
            end
            MODE_OUTSIDE_RANGE: begin
                trig = addr_below_a | addr_above_b;
            end
            default: begin
                // Codes 9 to 15 are silent
                trig = 1'b0;
            end
        endcase
    end

    // Event-only modes force a begin trace
    logic begin_trace;
    assign begin_trace = trigger_setup_q[TS_START_ON_TRIGGER]
                       | event_only;

    // Run end by the hardware itself
    logic auto_end;
    logic full_end;
    logic trig_end;
    assign full_end = armed & unit_en & begin_trace & fifo_full;
    assign trig_end = sample & ~begin_trace & trig;
    assign auto_end = full_end | trig_end;

    // Wishbone acknowledge: one cycle after the request, dropped after
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data is captured as ack rises; unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (req & ~ack_q & ~wb_we_i) begin
            case (wb_adr_i)
                OFS_CONTROL: begin
                    rdata_q <= {24'h000000, control_q};
                end
                OFS_TRIGGER_SETUP: begin
                    // Bits 5:4 are never stored, so read zero
                    rdata_q <= {24'h000000, trigger_setup_q};
                end
                OFS_RUN_STATUS: begin
                    rdata_q <= {24'h000000, a_hit_q, b_hit_q,
                                armed & unit_en, 1'b0,
                                valid_count_q};
                end
                OFS_FIFO_HIGH_BYTE: begin
                    // Event-only data lives in the low byte alone
                    rdata_q <= {24'h000000,
                                event_only ? 8'h00 : fifo_high_byte};
                end
                OFS_FIFO_LOW_BYTE: begin
                    rdata_q <= {24'h000000, fifo_low_byte};
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Control register; the capture enable also falls at run end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            control_q <= CONTROL_RESET;
        end else if (ctl_wr) begin
            // Capture enable needs the unit enabled in the same write
            control_q <= {wb_dat_i[7],
                          wb_dat_i[6] & wb_dat_i[7] & ~auto_end,
                          wb_dat_i[5:4], 4'h0};
        end else if (auto_end) begin
            control_q[CTL_CAPTURE_ENABLE] <= 1'b0;
        end
    end

    // Trigger setup: frozen while a run is armed
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            trigger_setup_q <= TRIGGER_SETUP_RESET;
        end else if (wr_fire & (wb_adr_i == OFS_TRIGGER_SETUP) & ~armed) begin
            trigger_setup_q <= wb_dat_i[7:0] & TS_WRITE_MASK;
        end
    end
    // Run status has no write path at all

    // Hit flags: cleared at start, set by qualified matches while running
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            a_hit_q <= 1'b0;
            b_hit_q <= 1'b0;
        end else if (run_start) begin
            a_hit_q <= 1'b0;
            b_hit_q <= 1'b0;
        end else if (sample) begin
            a_hit_q <= a_hit_q | ma;
            b_hit_q <= b_hit_q | mb;
        end
    end

    // A-then-B sequencing restarts with every run
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            seq_q <= SEQ_WAIT_A;
        end else if (run_start) begin
            seq_q <= SEQ_WAIT_A;
        end else if (sample & ma) begin
            seq_q <= SEQ_A_SEEN;
        end
    end

    // Begin trace storage starts at the trigger; end trace stores at once
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            storing_q <= 1'b0;
        end else if (run_start | ~armed) begin
            storing_q <= 1'b0;
        end else if (sample & trig) begin
            storing_q <= 1'b1;
        end
    end

    // Storage controls to the FIFO datapath
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            store_en_q <= 1'b0;
            store_evt_q <= 1'b0;
            clear_q <= 1'b0;
        end else begin
            // End trace fills circularly until the trigger
            store_en_q <= armed & unit_en & ~auto_end & ~event_only
                        & (~begin_trace | storing_q | (sample & trig));
            store_evt_q <= sample & evt & ~fifo_full;
            clear_q <= run_start;
        end
    end

    // Valid count: cleared at start, latched at run end only
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            valid_count_q <= VALID_COUNT_RESET;
        end else if (run_start) begin
            valid_count_q <= VALID_COUNT_RESET;
        end else if (auto_end | manual_stop) begin
            valid_count_q <= fifo_count;
        end
        // FIFO reads never touch it; host keeps its own tally
    end

    // Low-byte reads advance the FIFO; held off while armed
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            advance_q <= 1'b0;
        end else begin
            advance_q <= rd_fire & (wb_adr_i == OFS_FIFO_LOW_BYTE)
                       & ~armed;
        end
    end

    // Break request: one pulse at the run-ending event
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            brk_q <= 1'b0;
        end else begin
            brk_q <= control_q[CTL_BREAK_REQUEST_ENABLE]
                   & auto_end;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign fifo_advance = advance_q;
    assign store_enable = store_en_q;
    assign store_event = store_evt_q;
    assign fifo_clear = clear_q;
    assign break_request = brk_q;
    assign break_tag = control_q[CTL_BREAK_TAG];

endmodule

// ===== dbg_trig_checker_assertions.sv
// Checker for the debug trigger block, bound from the bench.
// Sees only top ports; one clock, sync reset.
`timescale 1ns/1ps
module dbg_trig_checker
    import dbg_trig_pkg::*;
#(parameter int COUNT_W = 4) (
    input wire logic clk_sys, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i,
    input wire logic [7:0] wb_adr_i, fifo_low_byte, fifo_high_byte,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i, wb_dat_o,
    input wire logic wb_ack_o, bus_cycle, match_a, match_b, data_match_b,
    input wire logic addr_below_a, addr_above_b, exec_a, exec_b, fifo_full,
    input wire logic [COUNT_W-1:0] fifo_count,
    input wire logic fifo_advance, store_enable, store_event, fifo_clear,
    input wire logic break_request, break_tag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic tag_q; // Last tag bit written
    logic low_q; // Low-byte read answered last edge
    // Read answered at this edge
    sequence s_rd(a);
        wb_ack_o && !wb_we_i && wb_adr_i == a;
    endsequence
    // Control write taking effect
    sequence s_ctl_wr;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CONTROL;
    endsequence
    // Helper flops; the tag copy avoids $past across a write
    always_ff @(posedge clk_sys) begin
        low_q <= wb_ack_o && !wb_we_i && wb_adr_i == OFS_FIFO_LOW_BYTE;
        if (sys_rst) begin
            tag_q <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0]
                && wb_adr_i == OFS_CONTROL) begin
            tag_q <= wb_dat_i[5];
        end
    end
    a_ack_next_cycle: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_setup_bits_zero: assert property
        (s_rd(OFS_TRIGGER_SETUP) |-> wb_dat_o[5:4] == 2'h0)
        else $error("setup bits 5:4 set");
    a_count_in_range: assert property
        (s_rd(OFS_RUN_STATUS) |-> wb_dat_o[3:0] <= 4'h8 && !wb_dat_o[4])
        else $error("status count bad");
    a_adv_after_low: assert property (fifo_advance |-> low_q)
        else $error("advance without low read");
    a_high_no_adv: assert property
        (s_rd(OFS_FIFO_HIGH_BYTE) |=> !fifo_advance)
        else $error("high read advanced");
    a_tag_follows: assert property (s_ctl_wr |=> ##1 break_tag == tag_q)
        else $error("tag not following");
    a_break_pulse: assert property
        (break_request |=> !break_request) else $error("break held");
endmodule

// ===== dbg_bus_model.sv
// Model of the CPU bus watch and FIFO facing the trigger block.
// Bench gives one access per go pulse and the FIFO fill level.
`timescale 1ns/1ps
module dbg_bus_model (
    input wire logic clk_sys, sys_rst, go, fifo_advance,
    input wire logic [6:0] hit,
    input wire logic [3:0] fill,
    output logic bus_cycle, match_a, match_b, data_match_b,
    output logic addr_below_a, addr_above_b, exec_a, exec_b, fifo_full,
    output logic [3:0] fifo_count,
    output logic [7:0] fifo_low_byte, fifo_high_byte
);
    logic [6:0] hit_q; // Results on the watch lines
    logic [2:0] rd_q; // Word the FIFO presents
    // Off-cycle the lines flip, so a stale match never looks fresh
    always_ff @(posedge clk_sys) begin
        bus_cycle <= go && !sys_rst;
        hit_q <= sys_rst ? 7'h00 : (go ? hit : ~hit_q);
    end
    assign {exec_b, exec_a, addr_above_b, addr_below_a} = hit_q[6:3];
    assign {data_match_b, match_b, match_a} = hit_q[2:0];
    // Only the advance pulse moves the FIFO on
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_q <= 3'h0;
        end else if (fifo_advance) begin
            rd_q <= rd_q + 3'h1;
        end
    end
    assign fifo_low_byte = {5'h15, rd_q};
    assign fifo_high_byte = {5'h0A, rd_q};
    assign fifo_count = fill; // Level set by the bench
    assign fifo_full = fill == 4'h8;
endmodule

// ===== debug_trigger_status_control_tb.sv
// Bench for the debug trigger and run-status block.
// Needs the bus model and checker compiled before it.
`timescale 1ns/1ps
module debug_trigger_status_control_tb
    import dbg_trig_pkg::*;
;
    localparam int COUNT_W = 4; // Fixed by the design
    logic clk_sys = 1'b0, sys_rst = 1'b1, go = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, fifo_low_byte, fifo_high_byte, e;
    logic [3:0] wb_sel_i = 4'h0, fill = 4'h0, fifo_count, f;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [6:0] hit = 7'h00, h; // a,b,data,below,above,exec a,exec b
    logic wb_ack_o, bus_cycle, match_a, match_b, data_match_b, exec_a;
    logic addr_below_a, addr_above_b, exec_b, fifo_full, fifo_advance;
    logic store_enable, store_event, fifo_clear, break_request, break_tag;
    logic t; // Trigger expected
    int miscompares = 0, checked = 0, brk = 0, tly = 0;
    int clr = 0, sev = 0, sx = 0; // Clear and event pulses seen, expected
    debug_trigger_status_control #(.COUNT_W(COUNT_W)) dut_u (.*);
    dbg_bus_model far_u (.*);
    always #5 clk_sys = ~clk_sys;
    // Break pulses seen; one per hardware run end (full or trigger) with break enabled
    always @(posedge clk_sys) if (break_request === 1'b1) brk++;
    // FIFO clear pulses, one per run start; stored B events
    always @(posedge clk_sys) if (fifo_clear === 1'b1) clr++;
    always @(posedge clk_sys) if (store_event === 1'b1) sev++;
    task automatic cmp(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Classic single cycle; the wait is bounded
    task automatic bus(input logic w, input logic [7:0] a, d);
        int n;
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n >= 20) begin
            miscompares++;
            tally_and_finish();
        end
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, d);
        bus(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] x,
            input string nm);
        bus(1'b0, a, 8'h00);
        cmp(nm, rd, x);
    endtask
    // One CPU access carrying the given comparator results
    task automatic access(input logic [6:0] x);
        @(posedge clk_sys);
        go <= 1'b1;
        hit <= x;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // Trigger from one fresh access with no earlier A seen
    function automatic logic trig(input logic [3:0] m, input logic [6:0] x);
        case (m)
            4'h0: return x[0];
            4'h1: return x[0] | x[1];
            4'h5: return x[0] & x[2];
            4'h6: return x[0] & !x[2];
            4'h7: return !x[3] & !x[4];
            4'h8: return x[3] | x[4];
            default: return 1'b0; // Sequence, event-only, unused codes
        endcase
    endfunction
    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // The run needs under six hundred cycles; this is far beyond
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'hB1933E79));
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rc(8'h14, 32'h0, "unmapped");
        wr(OFS_RUN_STATUS, 8'hFF);
        rc(OFS_RUN_STATUS, 32'h0, "sts");
        wr(OFS_TRIGGER_SETUP, 8'hFF);
        rc(OFS_TRIGGER_SETUP, 32'hCF, "setup");
        wr(OFS_CONTROL, 8'h40);
        rc(OFS_RUN_STATUS, 32'h0, "sts");
        $display("test registers done");
        // A match only counts once its opcode executes
        fill <= 4'h3;
        wr(OFS_TRIGGER_SETUP, 8'h80);
        wr(OFS_CONTROL, 8'hC0);
        access(7'h01);
        rc(OFS_RUN_STATUS, 32'h20, "sts");
        access(7'h21);
        rc(OFS_RUN_STATUS, 32'h83, "sts");
        rc(OFS_CONTROL, 32'h80, "ctl");
        $display("test exec_qualify done");
        fill <= 4'h5;
        wr(OFS_TRIGGER_SETUP, 8'h02);
        wr(OFS_CONTROL, 8'hC0);
        access(7'h01);
        rc(OFS_RUN_STATUS, 32'hA0, "sts");
        access(7'h02);
        rc(OFS_RUN_STATUS, 32'hC5, "sts");
        $display("test a_then_b done");
        // Every mode code with random comparator results
        for (int m = 0; m < 16; m++) begin
            h = 7'($urandom());
            f = 4'($urandom_range(7));
            fill <= f;
            wr(OFS_TRIGGER_SETUP, 8'(m));
            wr(OFS_CONTROL, 8'hC0);
            wr(OFS_TRIGGER_SETUP, 8'hFF);
            rc(OFS_TRIGGER_SETUP, 32'(m), "setup");
            access(h);
            t = trig(4'(m), h);
            // Event-only B stores one word per B match
            sx += (m == 3 && h[1]) ? 1 : 0;
            e = {h[0], h[1], !t, 1'b0, t ? f : 4'h0};
            rc(OFS_RUN_STATUS, e, "sts");
            wr(OFS_CONTROL, 8'h00);
            e[5] = 1'b0;
            e[3:0] = f;
            rc(OFS_RUN_STATUS, e, "sts");
        end
        cmp("event", sev, sx);
        $display("test modes done");
        // Begin trace with break on: full ends the run
        fill <= 4'h0;
        wr(OFS_TRIGGER_SETUP, 8'h40);
        wr(OFS_CONTROL, 8'hF0);
        access(7'h01);
        rc(OFS_RUN_STATUS, 32'hA0, "sts");
        cmp("store", store_enable, 1);
        fill <= 4'h8;
        repeat (4) @(posedge clk_sys);
        rc(OFS_RUN_STATUS, 32'h88, "sts");
        cmp("store", store_enable, 0);
        cmp("break", brk, 1);
        cmp("clear", clr, 19);
        $display("test begin_trace done");
        // Host keeps its own tally; the count must not move
        repeat (3) begin
            rc(OFS_FIFO_HIGH_BYTE, {5'h0A, 3'(tly)}, "high");
            rc(OFS_FIFO_LOW_BYTE, {5'h15, 3'(tly)}, "low");
            tly++;
        end
        rc(OFS_RUN_STATUS, 32'h88, "sts");
        $display("test fifo_read done");
        tally_and_finish();
    end
endmodule
bind debug_trigger_status_control dbg_trig_checker
    #(.COUNT_W(COUNT_W)) chk_u (.*);
